/* lcdrx_asserts.sv */
// Checker for the display link: watches the resolved lines and the device end's drive.
// Assumes both ends run on clock, so the lines only change at its edges.
`timescale 1ns/1ps
module lcdrx_asserts (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Link lines
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaDevOe,
   input wire logic sdaDevOut,
   // Strap
   input wire logic slave_address_select_pin
);
   // ****************************************************************
   // Frame tracking
   // ****************************************************************
   logic       sclP_q, sdaP_q, sel_q, inCmd_q;
   logic [3:0] bitCnt_q;
   logic [2:0] byteIdx_q;
   logic [7:0] shift_q;
   // Start is only a falling data line while the clock stays high
   wire        startEv = sclP_q && scl && sdaP_q && !sda;
   wire        sclRise = !sclP_q && scl;
   wire        ackSlot = sclRise && (bitCnt_q == 4'h8);
   wire        addrHit = (shift_q[7:2] == 6'h1C) && (shift_q[1] == slave_address_select_pin);
   wire        addrOk  = addrHit && !shift_q[0];
   // Line history and the eight data bits of the current byte
   always_ff @(posedge clock) begin
      sclP_q  <= scl;
      sdaP_q  <= sda;
      shift_q <= (sclRise && bitCnt_q != 4'h8) ? {shift_q[6:0], sda} : shift_q;
   end
   // Counts restart at every start, so a cut transfer cannot skew them
   always_ff @(posedge clock) begin
      if (!rst_n || startEv) begin
         bitCnt_q  <= 4'h0;
         byteIdx_q <= 3'h0;
      end else if (sclRise) begin
         bitCnt_q  <= (bitCnt_q == 4'h8) ? 4'h0 : bitCnt_q + 4'h1;
         byteIdx_q <= (ackSlot && byteIdx_q != 3'h7) ? byteIdx_q + 3'h1 : byteIdx_q;
      end
   end
   // Selection and command phase as the device ought to see them
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sel_q   <= 1'h0;
         inCmd_q <= 1'h0;
      end else if (ackSlot && byteIdx_q == 3'h0) begin
         sel_q   <= addrOk;
         inCmd_q <= 1'h1;
      end else if (ackSlot && inCmd_q) begin
         inCmd_q <= shift_q[7];
      end
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_clock_low;
      ##[1:8] !scl;
   endsequence
   property p_ack_slot; sclRise && sdaDevOe |-> bitCnt_q == 4'h8; endproperty
   a_ack_slot: assert property (p_ack_slot)
      else $error("device drives data outside the acknowledge slot");
   property p_addr_ack; ackSlot && byteIdx_q == 3'h0 |-> sdaDevOe == addrOk; endproperty
   a_addr_ack: assert property (p_addr_ack)
      else $error("address acknowledge does not match address and strap");
   property p_cmd_ack; ackSlot && byteIdx_q != 3'h0 && sel_q && inCmd_q |-> sdaDevOe; endproperty
   a_cmd_ack: assert property (p_cmd_ack)
      else $error("command byte not acknowledged");
   property p_ignore; ackSlot && byteIdx_q != 3'h0 && !sel_q |-> !sdaDevOe; endproperty
   a_ignore: assert property (p_ignore)
      else $error("unselected device acknowledged");
   property p_low_only; sdaDevOe |-> !sdaDevOut; endproperty
   a_low_only: assert property (p_low_only)
      else $error("device drives data high");
   property p_hold_high; sdaDevOe && scl |=> sdaDevOe || !scl; endproperty
   a_hold_high: assert property (p_hold_high)
      else $error("device released data while clock high");
   property p_ack_hold; ackSlot && sdaDevOe |-> (!sda) throughout s_clock_low; endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("acknowledge not low for the whole clock pulse");
   property p_start_clock; startEv |-> ##[1:12] !scl; endproperty
   a_start_clock: assert property (p_start_clock)
      else $error("clock not driven low after start");
endmodule : lcdrx_asserts

/* lcdrx_cfg.svh */
// Constants for the display command receiver link: addresses, command fields, timing.
// Assumes inclusion by the package and the two link ends only.
`ifndef LCDRX_CFG_SVH
`define LCDRX_CFG_SVH
// ****************************************************************
// Address and command fields
// ****************************************************************
`define LCDRX_ADDR_HIGH      6'h1C
`define LCDRX_CONT_BIT       7
`define LCDRX_PTR_CMD_BIT    6
`define LCDRX_DEV_SEL_TOP    5'h18
`define LCDRX_MODE_SET_TOP   3'h4
`define LCDRX_RAM_WORDS      40
// ****************************************************************
// Timing
// ****************************************************************
`define LCDRX_CLK_HZ         20000000
`define LCDRX_BOOT_WAIT_US   1000
`define LCDRX_CMD_WAIT_US    10
`define LCDRX_BOOT_CYC       ((`LCDRX_BOOT_WAIT_US * (`LCDRX_CLK_HZ / 1000000)))
`define LCDRX_CMD_CYC        ((`LCDRX_CMD_WAIT_US * (`LCDRX_CLK_HZ / 1000000)))
`define LCDRX_SCL_HALF_CYC   4
`endif

/* lcdrx_device.sv */
// Display driver receiver end: write-only bus slave, command decoder, RAM loader.
// Assumes the master keeps bus timing far slower than clock (400 ns period or more).
//
// Functional notes
// - eight data bits then acknowledge slot
// - addressed receiver acknowledges address and command bytes
// - acknowledger holds data low whole high
// - slave receiver only, drives acknowledge
// - unlimited bytes between start and stop
// - answer only addresses 0111000 and 0111001
// - address bit one matches select pin
// - master sends bit zero low writes
// - matching devices acknowledge, others ignore
// - command bit seven flags continuation
// - all selected devices acknowledge commands
// - data written at pointer, pointers advance
// - data acknowledged only on sub-address match
// - master ends with stop or restart
// - decoder splits commands, controller loads RAM
// - bit six low loads data pointer
// - master waits after reset before commands
// - start and stop detected clock high
// - pointer advances eight four three two
// - mismatch skips write, pointer still advances
// - pointer overflow increments sub-address counter
`timescale 1ns/1ps
module lcdrx_device
   import lcdrx_pkg::*;
#(
   parameter int RAM_WORDS = `LCDRX_RAM_WORDS
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Link
   lcdrx_if.device         bus,
   // Strap pins
   input  wire logic       slave_address_select_pin,
   input  wire logic       hw_subaddress_bit0,
   input  wire logic       hw_subaddress_bit1,
   input  wire logic       hw_subaddress_bit2,
   // Display state
   output lcdrx_mode_e     driveMode,
   output logic            displayEnable,
   output logic [5:0]      dataPointer,
   output logic [2:0]      subAddress,
   // RAM read port
   input  wire logic [5:0] ramRdAddr,
   output logic [3:0]      ramRdData
);
   initial begin
      if (RAM_WORDS < 8 || RAM_WORDS > 64) $error("RAM_WORDS out of range");
   end

   typedef enum logic [2:0] {IDLE, ADDR, CMD, DATA, IGNORE} lcdrx_phase_e;

   // ****************************************************************
   // Bus sampling and condition detection
   // ****************************************************************
   logic [1:0] lineSync;
   logic       sclPrev_q;
   logic       sdaPrev_q;
   lcdrx_sync #(.WIDTH(2)) u_sync (
      .clock   (clock),
      .rst_n   (rst_n),
      .asyncIn ({bus.scl, bus.sda}),
      .syncOut (lineSync)
   );
   wire scl     = lineSync[1];
   wire sda     = lineSync[0];
   wire sclRise = scl && !sclPrev_q;
   wire sclFall = !scl && sclPrev_q;
   wire startSeen = scl && sclPrev_q && sdaPrev_q && !sda;
   wire stopSeen  = scl && sclPrev_q && !sdaPrev_q && sda;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclPrev_q <= scl;
         sdaPrev_q <= sda;
      end
   end

   // ****************************************************************
   // Byte framing
   // ****************************************************************
   lcdrx_phase_e phase_q;
   logic [3:0]   bitCnt_q;
   logic [7:0]   shift_q;
   logic         ackDrive_q;
   logic         ackPend_q;
   // bit nine is the acknowledge slot
   wire   byteDone  = sclRise && bitCnt_q == 4'h7;
   // Count 9 marks the acknowledge pulse itself, whether or not we drive it
   wire   ackSlotEnd = sclFall && bitCnt_q == 4'h9;
   wire [7:0] rxByte = {shift_q[6:0], sda};
   wire [2:0] hwSub  = {hw_subaddress_bit2, hw_subaddress_bit1, hw_subaddress_bit0};

   wire addrHit = rxByte[7:2] == `LCDRX_ADDR_HIGH && rxByte[1] == slave_address_select_pin
                  && !rxByte[0];
   wire subMatch = subAddress == hwSub;
   wire ackThis  = (phase_q == ADDR && addrHit) || phase_q == CMD
                   || (phase_q == DATA && subMatch);

   // ****************************************************************
   // Command decoding
   // ****************************************************************
   // continuation bit splits command and data
   wire contFlag   = rxByte[`LCDRX_CONT_BIT];
   wire isPtrLoad  = !rxByte[`LCDRX_PTR_CMD_BIT];
   wire isDevSel   = rxByte[6:2] == `LCDRX_DEV_SEL_TOP;
   wire isModeSet  = rxByte[6:4] == `LCDRX_MODE_SET_TOP;
   // command bytes taken at the byte end in command phase
   wire cmdStrobe  = byteDone && phase_q == CMD;
   wire dataStrobe = byteDone && phase_q == DATA;

   // only acknowledge ever drives the line
   // held low across the whole high phase
   assign bus.sdaDevOut = 1'b0;
   assign bus.sdaDevOe  = ackDrive_q;

   // no byte count, loops until stop
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         phase_q    <= IDLE;
         bitCnt_q   <= 4'h0;
         shift_q    <= 8'h00;
         ackDrive_q <= 1'b0;
         ackPend_q  <= 1'b0;
      end else if (startSeen) begin
         phase_q    <= ADDR;
         bitCnt_q   <= 4'h0;
         ackDrive_q <= 1'b0;
         ackPend_q  <= 1'b0;
      end else if (stopSeen) begin
         phase_q    <= IDLE;
         ackDrive_q <= 1'b0;
         ackPend_q  <= 1'b0;
      end else if (phase_q != IDLE && phase_q != IGNORE) begin
         if (sclRise && bitCnt_q < 4'h8) begin
            shift_q  <= rxByte;
         end
         if (byteDone) begin
            ackPend_q <= ackThis;
            bitCnt_q  <= 4'h8;
            unique case (phase_q)
               ADDR:    phase_q <= addrHit ? CMD : IGNORE;
               CMD:     phase_q <= contFlag ? CMD : DATA;
               default: phase_q <= phase_q;
            endcase
         end else if (sclRise && bitCnt_q < 4'h8) begin
            bitCnt_q <= bitCnt_q + 4'h1;
         end
         // Drive only after clock falls so the line is settled before high
         // A refused byte still spends the ninth pulse, so it is never a data bit
         if (sclFall && bitCnt_q == 4'h8) begin
            ackDrive_q <= ackPend_q;
            ackPend_q  <= 1'b0;
            bitCnt_q   <= 4'h9;
         end else if (ackSlotEnd) begin
            ackDrive_q <= 1'b0;
            bitCnt_q   <= 4'h0;
         end
      end
   end

   // ****************************************************************
   // Display controller: pointer, sub-address, RAM
   // ****************************************************************
   logic [3:0] ram_q [RAM_WORDS];
   logic [5:0] ptr_q;
   logic [2:0] sub_q;
   logic [1:0] mode_q;
   logic       enable_q;
   wire [5:0] step = (mode_q == 2'd0) ? 6'd8 : (mode_q == 2'd1) ? 6'd4 :
                     (mode_q == 2'd2) ? 6'd3 : 6'd2;
   wire [6:0] ptrSum = {1'b0, ptr_q} + {1'b0, step};
   wire       ptrWrap = ptrSum >= 7'(RAM_WORDS);
   wire [6:0] ptrNext = ptrWrap ? ptrSum - 7'(RAM_WORDS) : ptrSum;
   // Bits per word and address for each bit of the byte
   wire [2:0] perWord = (mode_q == 2'd0) ? 3'd1 : (mode_q == 2'd1) ? 3'd2 :
                        (mode_q == 2'd2) ? 3'd3 : 3'd4;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ptr_q    <= 6'h00;
         sub_q    <= 3'h0;
         mode_q   <= 2'd0;
         enable_q <= 1'b0;
      end else if (cmdStrobe) begin
         if (isPtrLoad) begin
            ptr_q <= rxByte[5:0];
         end else if (isDevSel) begin
            sub_q <= rxByte[2:0];
         end else if (isModeSet) begin
            enable_q <= rxByte[3];
            mode_q   <= rxByte[1:0];
         end
      end else if (dataStrobe) begin
         ptr_q <= ptrNext[5:0];
         if (ptrWrap) begin
            sub_q <= sub_q + 3'h1;
         end
      end
   end

   // MSB first fills row 0 of the first word; bit 2 of the third mux3 word is untouched
   always_ff @(posedge clock) begin
      if (dataStrobe && subMatch) begin
         for (int b = 0; b < 8; b++) begin
            automatic int w = ptr_q + (b / perWord);
            automatic int r = b % perWord;
            if (w < RAM_WORDS) begin
               ram_q[w][r] <= rxByte[7-b];
            end
         end
      end
   end

   assign driveMode     = lcdrx_mode_e'(mode_q);
   assign displayEnable = enable_q;
   assign dataPointer   = ptr_q;
   assign subAddress    = sub_q;
   assign ramRdData     = (ramRdAddr < 6'(RAM_WORDS)) ? ram_q[ramRdAddr] : 4'h0;
endmodule : lcdrx_device

/* lcdrx_if.sv */
// Two-wire link between the bus master and the display receiver.
// Both lines are open drain with pull-ups; the wire level is resolved here.
`timescale 1ns/1ps
interface lcdrx_if;
   logic sclOut;
   logic sclOe;
   logic sdaMstOut;
   logic sdaMstOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic scl;
   logic sda;
   // Wired-and with pull-ups
   assign scl = !(sclOe && !sclOut);
   assign sda = !((sdaMstOe && !sdaMstOut) || (sdaDevOe && !sdaDevOut));
   modport master (output sclOut, sclOe, sdaMstOut, sdaMstOe, input scl, sda);
   modport device (output sdaDevOut, sdaDevOe, input scl, sda);
endinterface : lcdrx_if

/* lcdrx_master.sv */
// Bus master end: waits the power-up delays, then sends one byte per request, with a stop after the last byte.
// Assumes the user holds the byte stable while byteValid is high.
`timescale 1ns/1ps
module lcdrx_master
   import lcdrx_pkg::*;
#(
   parameter int BOOT_CYC = `LCDRX_BOOT_CYC,
   parameter int CMD_CYC  = `LCDRX_CMD_CYC,
   parameter int HALF_CYC = `LCDRX_SCL_HALF_CYC
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst_n,
   // Link
   lcdrx_if.master         bus,
   // Chip reset output
   output logic            active_low_chip_reset,
   // Byte request
   input  wire logic       byteValid,
   input  wire lcdrx_byte_t byteData,
   input  wire logic       byteLast,
   output logic            byteReady,
   output logic            ackSeen,
   output logic            ready
);
   initial begin
      if (HALF_CYC < 2) $error("HALF_CYC too small");
   end
   typedef enum logic [2:0] {BOOT, WAIT, IDLE, START, BITS, STOP} lcdrx_mst_e;
   lcdrx_mst_e st_q;
   logic [31:0] cnt_q;
   logic [3:0]  bit_q;
   logic [8:0]  sh_q;
   logic        last_q, sclLow_q, sdaLow_q, ack_q;
   wire tick = cnt_q == 32'd0;
   assign bus.sclOut = 1'b0;
   assign bus.sclOe  = sclLow_q;
   assign bus.sdaMstOut = 1'b0;
   assign bus.sdaMstOe  = sdaLow_q;
   // Next byte is taken while the clock is low after the acknowledge pulse
   assign byteReady = st_q == IDLE || (st_q == BITS && bit_q == 4'd9 && tick && sclLow_q
                      && !last_q);
   assign ackSeen = ack_q;
   assign ready   = st_q != BOOT && st_q != WAIT;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_q <= BOOT; cnt_q <= 32'(BOOT_CYC); bit_q <= 4'd0; sh_q <= 9'h1FF;
         last_q <= 1'b0; sclLow_q <= 1'b0; sdaLow_q <= 1'b0; ack_q <= 1'b0;
         active_low_chip_reset <= 1'b0;
      end else begin
         cnt_q <= tick ? 32'(HALF_CYC) : cnt_q - 32'd1;
         unique case (st_q)
            BOOT: if (tick) begin
               active_low_chip_reset <= 1'b1; st_q <= WAIT; cnt_q <= 32'(CMD_CYC);
            end
            WAIT: if (tick) st_q <= IDLE;
            IDLE: if (byteValid) begin
               sh_q <= {byteData, 1'b1}; last_q <= byteLast; sdaLow_q <= 1'b1;
               st_q <= START; cnt_q <= 32'(HALF_CYC);
            end
            START: if (tick) begin
               sclLow_q <= 1'b1; bit_q <= 4'd0; st_q <= BITS;
            end
            BITS: if (tick) begin
               // Data moves on the same edge that releases the clock, never while it is high, else it would mimic start or stop
               if (sclLow_q && bit_q == 4'd9) begin
                  if (last_q) begin
                     sdaLow_q <= 1'b1; st_q <= STOP;
                  end else if (byteValid) begin
                     sh_q <= {byteData, 1'b1}; last_q <= byteLast; bit_q <= 4'd0;
                  end
               end else if (sclLow_q) begin
                  sdaLow_q <= !sh_q[8]; sclLow_q <= 1'b0;
               end else if (bit_q == 4'd8) begin
                  ack_q <= !bus.sda; sclLow_q <= 1'b1; bit_q <= 4'd9;
               end else begin
                  sh_q <= {sh_q[7:0], 1'b1}; sclLow_q <= 1'b1; bit_q <= bit_q + 4'd1;
               end
            end
            STOP: if (tick) begin
               if (sclLow_q) sclLow_q <= 1'b0;
               else begin
                  sdaLow_q <= 1'b0; st_q <= IDLE;
               end
            end
         endcase
      end
   end
endmodule : lcdrx_master

/* lcdrx_pkg.sv */
// Types shared by both ends of the display command link.
// Assumes the configuration header is on the include path.
`include "lcdrx_cfg.svh"
package lcdrx_pkg;
   // ****************************************************************
   // Drive modes
   // ****************************************************************
   typedef enum logic [1:0] {
      LCDRX_STATIC,
      LCDRX_MUX2,
      LCDRX_MUX3,
      LCDRX_MUX4
   } lcdrx_mode_e;
   typedef logic [7:0] lcdrx_byte_t;
endpackage : lcdrx_pkg

/* lcdrx_sync.sv */
// Two-flop synchroniser for the bus lines.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
module lcdrx_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_q;
   // Idle bus is high, so reset to ones
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_q  <= '1;
         syncOut <= '1;
      end else begin
         meta_q  <= asyncIn;
         syncOut <= meta_q;
      end
   end
endmodule : lcdrx_sync

/* tb.sv */
// Self-checking bench: the master end talks to the device end over the link.
// Assumes shortened power-up counts and one clock for both ends.
`timescale 1ns/1ps
module tb;
   import lcdrx_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic        clock = 1'h0;
   logic        rst_n = 1'h0;
   logic        byteValid = 1'h0;
   lcdrx_byte_t byteData = 8'h00;
   logic        byteLast = 1'h0;
   logic        saPin = 1'h0;
   logic [5:0]  ramRdAddr = 6'h00;
   logic        byteReady, ackSeen, ready, chipRstN, displayEnable;
   lcdrx_mode_e driveMode;
   logic [5:0]  dataPointer;
   logic [2:0]  subAddress;
   logic [3:0]  ramRdData;
   int          n_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   int          n;
   // Device sits in reset until the master lets it go
   wire         devRstN = rst_n && chipRstN;
   logic [7:0]  addrTab [7] = '{8'h70, 8'h72, 8'h71, 8'h50, 8'h72, 8'h73, 8'h70};
   logic        saTab   [7] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
   logic        ackTab  [7] = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0};
   logic [7:0]  stepTab [4] = '{8'h08, 8'h04, 8'h03, 8'h02};
   logic [7:0]  dataTab [4] = '{8'hA5, 8'h3C, 8'h96, 8'hE1};
   always #25 clock = ~clock;
   // ****************************************************************
   // Instances
   // ****************************************************************
   lcdrx_if u_lcdrx_if ();
   lcdrx_master #(.BOOT_CYC(20), .CMD_CYC(5)) u_lcdrx_master (
      .clock(clock), .rst_n(rst_n), .bus(u_lcdrx_if.master),
      .active_low_chip_reset(chipRstN), .byteValid(byteValid), .byteData(byteData),
      .byteLast(byteLast), .byteReady(byteReady), .ackSeen(ackSeen), .ready(ready));
   lcdrx_device u_lcdrx_device (
      .clock(clock), .rst_n(devRstN), .bus(u_lcdrx_if.device),
      .slave_address_select_pin(saPin), .hw_subaddress_bit0(1'h0),
      .hw_subaddress_bit1(1'h0), .hw_subaddress_bit2(1'h0), .driveMode(driveMode),
      .displayEnable(displayEnable), .dataPointer(dataPointer), .subAddress(subAddress),
      .ramRdAddr(ramRdAddr), .ramRdData(ramRdData));
   lcdrx_asserts u_lcdrx_asserts (
      .clock(clock), .rst_n(rst_n), .scl(u_lcdrx_if.scl), .sda(u_lcdrx_if.sda),
      .sdaDevOe(u_lcdrx_if.sdaDevOe), .sdaDevOut(u_lcdrx_if.sdaDevOut),
      .slave_address_select_pin(saPin));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // Hold the byte until the accepting edge, then wait for the transfer to finish
   task automatic put(input logic [7:0] b, input logic last, input logic expAck);
      byteValid = 1'h1;
      byteData  = b;
      byteLast  = last;
      while (byteReady !== 1'h1) begin
         @(posedge clock);
         #2;
      end
      @(posedge clock);
      #2 byteValid = 1'h0;
      @(posedge clock);
      #2;
      while (byteReady !== 1'h1) begin
         @(posedge clock);
         #2;
      end
      check("ack", {7'h00, expAck}, {7'h00, ackSeen});
   endtask : put
   task automatic peek(input logic [5:0] a, input logic [3:0] exp);
      ramRdAddr = a;
      @(posedge clock);
      #2 check("ram", {4'h0, exp}, {4'h0, ramRdData});
   endtask : peek
   task automatic boot;
      n = 0;
      while (ready !== 1'h1) begin
         @(posedge clock);
         #2 n++;
      end
      check("boot", 8'h01, {7'h00, n >= 20});
   endtask : boot
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : close_out
   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         $display("BAD timeout expected done seen hung");
         close_out();
      end
   end
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      repeat (10) @(posedge clock);
      #2 rst_n = 1'h1;
      boot();
      // Address decode: strap level, read bit and fixed high bits
      for (int i = 0; i < 7; i++) begin
         saPin = saTab[i];
         put(addrTab[i], 1'h0, ackTab[i]);
         put(8'h00, 1'h1, ackTab[i]);
      end
      saPin = 1'h0;
      $display("test address done");
      // Every drive mode: pointer step and RAM filling order
      for (int m = 0; m < 4; m++) begin
         put(8'h70, 1'h0, 1'h1);
         put(8'hC8 | 8'(m), 1'h0, 1'h1);
         put(8'hE0, 1'h0, 1'h1);
         put(8'h00, 1'h0, 1'h1);
         put(dataTab[m], 1'h1, 1'h1);
         check("mode", 8'(m), {6'h00, driveMode});
         check("enable", 8'h01, {7'h00, displayEnable});
         check("pointer", stepTab[m], {2'h0, dataPointer});
         for (int i = 0; i < 8; i++) begin
            ramRdAddr = 6'(i / (m + 1));
            @(posedge clock);
            #2 check("row", {7'h00, dataTab[m][7 - i]}, {7'h00, ramRdData[i % (m + 1)]});
         end
      end
      $display("test modes done");
      // Pointer wrap moves to the next sub-address, which this device does not own
      put(8'h70, 1'h0, 1'h1);
      put(8'hCB, 1'h0, 1'h1);
      put(8'hE0, 1'h0, 1'h1);
      put(8'h26, 1'h0, 1'h1);
      put(8'h5A, 1'h0, 1'h1);
      check("pointer", 8'h00, {2'h0, dataPointer});
      check("sub", 8'h01, {5'h00, subAddress});
      put(8'h77, 1'h1, 1'h0);
      check("pointer", 8'h02, {2'h0, dataPointer});
      peek(6'h26, 4'hA);
      peek(6'h27, 4'h5);
      peek(6'h00, 4'h7);
      $display("test wrap done");
      // Reset in mid-transfer discards state, then a fresh transfer works
      put(8'h70, 1'h0, 1'h1);
      put(8'hC9, 1'h0, 1'h1);
      @(posedge clock);
      #2 rst_n = 1'h0;
      repeat (10) @(posedge clock);
      #2 check("pointer", 8'h00, {2'h0, dataPointer});
      check("sub", 8'h00, {5'h00, subAddress});
      check("mode", 8'h00, {6'h00, driveMode});
      check("enable", 8'h00, {7'h00, displayEnable});
      rst_n = 1'h1;
      boot();
      put(8'h70, 1'h0, 1'h1);
      put(8'h05, 1'h1, 1'h1);
      check("pointer", 8'h05, {2'h0, dataPointer});
      $display("test reset done");
      close_out();
   end
endmodule : tb
